/* File: rtl/pcp_regs.svh */
// Offsets, field positions, reset values and masks of the packet/clock/page bank
// Assumes a byte-wide register port with 5-bit addresses
`ifndef PCP_REGS_SVH
`define PCP_REGS_SVH
`define PCP_ADDR_CLKOUT        5'h1B
`define PCP_ADDR_PKTFMT        5'h1C
`define PCP_ADDR_NODE          5'h1D
`define PCP_ADDR_PKTCTL        5'h1E
`define PCP_ADDR_PAGE          5'h1F
`define PCP_RST_CLKOUT         8'hBC
`define PCP_RST_PKTFMT         8'h00
`define PCP_RST_NODE           8'h00
`define PCP_RST_PKTCTL         8'h40
`define PCP_RST_PAGE           8'h00
`define PCP_CLKOUT_EN_BIT      7
`define PCP_CLKDIV_HI          6
`define PCP_CLKDIV_LO          2
`define PCP_MAN_EN_BIT         7
`define PCP_PKTLEN_HI          6
`define PCP_LENMODE_BIT        7
`define PCP_PREAMB_HI          6
`define PCP_PREAMB_LO          5
`define PCP_SCRMB_BIT          4
`define PCP_CRC_EN_BIT         3
`define PCP_ADDRCMP_HI         2
`define PCP_ADDRCMP_LO         1
`define PCP_CRC_OK_BIT         0
`define PCP_AUTOCLR_DIS_BIT    7
`define PCP_FIFO_DIR_BIT       6
`define PCP_PAGE_HI            1
`define PCP_CLKOUT_MASK        8'hFC
`define PCP_PKTCTL_WMASK       8'hFE
`define PCP_PAGE_MASK          8'hC3
`define PCP_BCAST_LO           8'h00
`define PCP_BCAST_HI           8'hFF
`endif

/* File: rtl/pcp_pkg.sv */
// Types of the packet/clock/page bank
// Assumes pcp_regs.svh supplies the numeric constants
package pcp_pkg;
    typedef enum logic [1:0] {
        PCP_CMP_NONE,
        PCP_CMP_NODE,
        PCP_CMP_NODE_ZERO,
        PCP_CMP_NODE_ZERO_ONES
    } pcp_addr_cmp_t;
    typedef enum logic [1:0] {
        PCP_PAGE0,
        PCP_PAGE1,
        PCP_PAGE_RSV2,
        PCP_PAGE_RSV3
    } pcp_page_t;
endpackage

/* File: rtl/pcp_bank.sv */
// Packet handler, clock output and page configuration registers with their control decode
// Assumes a synchronous byte register port and a packet framer on clock_in
// What this block does
// - The clock output pin is driven only while the clock output enable bit is set.
// - The output clock is the crystal clock divided by twice the divider, zero meaning undivided.
// - Manchester coding is applied on transmit and receive only while its enable bit is set.
// - The packet length field is the exact size in fixed mode and the maximum in variable modes.
// - An eight-bit node address written by the host drives receive address filtering.
// - The length mode bit selects fixed length at 0 and variable length at 1.
// - The preamble is the two-bit field plus one bytes long.
// - Scrambling follows its enable bit and CRC work happens only while the CRC bit is set.
// - Address filtering compares against none, the node, node or 0x00, or node, 0x00 or 0xFF.
// - The CRC result is a read-only flag at bit 0 that the host clears by writing 1.
// - A failed receive CRC flushes the FIFO unless the auto-clear disable bit is set.
// - In standby host FIFO accesses go to the write FIFO at 0 and the read FIFO at 1.
// - Page code 00 selects page 0 and 01 selects page 1, other codes being unused.
// - The page register decodes at the same address on every page.
`timescale 1ns/100ps
`default_nettype none
`include "pcp_regs.svh"
module pcp_bank (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Register port
    input  wire logic [4:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    output logic            page1_sel_out,
    // Packet framer status
    input  wire logic       crc_done_in,
    input  wire logic       crc_pass_in,
    input  wire logic       rx_active_in,
    input  wire logic       standby_in,
    input  wire logic       rx_addr_valid_in,
    input  wire logic [7:0] rx_addr_byte_in,
    // Framer configuration
    output logic            manchester_en_out,
    output logic      [6:0] pkt_length_out,
    output logic            var_length_out,
    output logic      [2:0] preamble_bytes_out,
    output logic            scramble_en_out,
    output logic            crc_en_out,
    output logic            addr_match_out,
    output logic            fifo_flush_out,
    output logic            fifo_sel_read_out,
    output logic            fifo_sel_write_out,
    // Clock output pin
    output logic            clkout_out,
    output logic            clkout_oe_out
);
    logic       rst_meta_ff;
    logic       rst_sync_ff;
    logic [7:0] clkout_cfg_ff;
    logic [7:0] pkt_fmt_ff;
    logic [7:0] node_addr_ff;
    logic [7:0] pkt_ctl_ff;
    logic [7:0] page_ff;
    logic [4:0] div_cnt_ff;
    logic       clk_div_ff;
    logic       flush_ff;
    logic       addr_match_ff;
    logic [4:0] clk_div_val;
    logic       page0;
    logic       crc_en;
    logic       wr_page;
    logic       wr_clkout;
    logic       wr_pktfmt;
    logic       wr_node;
    logic       wr_pktctl;
    pcp_pkg::pcp_addr_cmp_t cmp_mode;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign page0  = (page_ff[`PCP_PAGE_HI:0] == pcp_pkg::PCP_PAGE0);
    assign crc_en = pkt_ctl_ff[`PCP_CRC_EN_BIT];
    assign cmp_mode = pcp_pkg::pcp_addr_cmp_t'(pkt_ctl_ff[`PCP_ADDRCMP_HI:`PCP_ADDRCMP_LO]);
    assign clk_div_val = clkout_cfg_ff[`PCP_CLKDIV_HI:`PCP_CLKDIV_LO];

    // Write decode; 0x1B..0x1E answer on page 0 only, the page register on every page
    assign wr_page   = reg_wr_in && (reg_addr_in == `PCP_ADDR_PAGE);
    assign wr_clkout = reg_wr_in && page0 && (reg_addr_in == `PCP_ADDR_CLKOUT);
    assign wr_pktfmt = reg_wr_in && page0 && (reg_addr_in == `PCP_ADDR_PKTFMT);
    assign wr_node   = reg_wr_in && page0 && (reg_addr_in == `PCP_ADDR_NODE);
    assign wr_pktctl = reg_wr_in && page0 && (reg_addr_in == `PCP_ADDR_PKTCTL);

    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            page_ff <= `PCP_RST_PAGE;
        end else if (wr_page) begin
            page_ff <= reg_wdata_in & `PCP_PAGE_MASK;
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            clkout_cfg_ff <= `PCP_RST_CLKOUT;
        end else if (wr_clkout) begin
            clkout_cfg_ff <= reg_wdata_in & `PCP_CLKOUT_MASK;
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pkt_fmt_ff <= `PCP_RST_PKTFMT;
        end else if (wr_pktfmt) begin
            pkt_fmt_ff <= reg_wdata_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            node_addr_ff <= `PCP_RST_NODE;
        end else if (wr_node) begin
            node_addr_ff <= reg_wdata_in;
        end
    end

    // CRC flag: a new result wins over a same-cycle host clear
    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pkt_ctl_ff <= `PCP_RST_PKTCTL;
        end else begin
            if (wr_pktctl) begin
                pkt_ctl_ff[7:1] <= reg_wdata_in[7:1];
                if (reg_wdata_in[`PCP_CRC_OK_BIT]) begin
                    pkt_ctl_ff[`PCP_CRC_OK_BIT] <= 1'b0;
                end
            end
            if (crc_done_in && crc_en) begin
                pkt_ctl_ff[`PCP_CRC_OK_BIT] <= crc_pass_in;
            end
        end
    end

    // Flush is a one-cycle pulse on a failed receive CRC
    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            flush_ff <= 1'b0;
        end else begin
            flush_ff <= crc_done_in && crc_en && !crc_pass_in && rx_active_in
                        && !page_ff[`PCP_AUTOCLR_DIS_BIT];
        end
    end

    // Address filter result, registered so the framer sees a clean level
    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            addr_match_ff <= 1'b0;
        end else if (rx_addr_valid_in) begin
            case (cmp_mode)
                pcp_pkg::PCP_CMP_NONE: addr_match_ff <= 1'b1;
                pcp_pkg::PCP_CMP_NODE: addr_match_ff <= (rx_addr_byte_in == node_addr_ff);
                pcp_pkg::PCP_CMP_NODE_ZERO:
                    addr_match_ff <= (rx_addr_byte_in == node_addr_ff)
                                  || (rx_addr_byte_in == `PCP_BCAST_LO);
                pcp_pkg::PCP_CMP_NODE_ZERO_ONES:
                    addr_match_ff <= (rx_addr_byte_in == node_addr_ff)
                                  || (rx_addr_byte_in == `PCP_BCAST_LO)
                                  || (rx_addr_byte_in == `PCP_BCAST_HI);
                default: addr_match_ff <= 1'b0;
            endcase
        end
    end

    // Divider toggles every M cycles, giving period 2*M; M = 0 bypasses to the crystal clock
    // A config write restarts the count so the first period at a new M is a whole one
    always_ff @(posedge clock_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            div_cnt_ff <= 5'h00;
            clk_div_ff <= 1'b0;
        end else if (wr_clkout) begin
            div_cnt_ff <= 5'h00;
        end else if (div_cnt_ff + 5'h01 >= clk_div_val) begin
            div_cnt_ff <= 5'h00;
            clk_div_ff <= ~clk_div_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 5'h01;
        end
    end

    // Bypass passes the clock combinationally; a glitch can appear when M changes
    assign clkout_out    = clkout_cfg_ff[`PCP_CLKOUT_EN_BIT]
                           ? ((clk_div_val == 5'h00) ? clock_in : clk_div_ff) : 1'b0;
    assign clkout_oe_out = clkout_cfg_ff[`PCP_CLKOUT_EN_BIT];

    always_comb begin
        reg_rdata_out = 8'h00;
        if (reg_addr_in == `PCP_ADDR_PAGE) begin
            reg_rdata_out = page_ff;
        end else if (page0) begin
            case (reg_addr_in)
                `PCP_ADDR_CLKOUT: reg_rdata_out = clkout_cfg_ff;
                `PCP_ADDR_PKTFMT: reg_rdata_out = pkt_fmt_ff;
                `PCP_ADDR_NODE:   reg_rdata_out = node_addr_ff;
                `PCP_ADDR_PKTCTL: reg_rdata_out = pkt_ctl_ff;
                default:          reg_rdata_out = 8'h00;
            endcase
        end
    end

    assign page1_sel_out      = (page_ff[`PCP_PAGE_HI:0] == pcp_pkg::PCP_PAGE1);
    assign manchester_en_out  = pkt_fmt_ff[`PCP_MAN_EN_BIT];
    assign pkt_length_out     = pkt_fmt_ff[`PCP_PKTLEN_HI:0];
    assign var_length_out     = pkt_ctl_ff[`PCP_LENMODE_BIT];
    assign preamble_bytes_out = {1'b0, pkt_ctl_ff[`PCP_PREAMB_HI:`PCP_PREAMB_LO]} + 3'h1;
    assign scramble_en_out    = pkt_ctl_ff[`PCP_SCRMB_BIT];
    assign crc_en_out         = crc_en;
    assign addr_match_out     = addr_match_ff;
    assign fifo_flush_out     = flush_ff;
    assign fifo_sel_read_out  = standby_in && page_ff[`PCP_FIFO_DIR_BIT];
    assign fifo_sel_write_out = standby_in && !page_ff[`PCP_FIFO_DIR_BIT];
endmodule
`default_nettype wire

/* File: verif/pcp_host_model.sv */
// Host model on the register port of the packet/clock/page bank
// Assumes the bench calls its tasks; it changes signals on the falling edge
`timescale 1ns/100ps
`default_nettype none
module pcp_host_model (
    input  wire logic       clock_in,
    input  wire logic [7:0] rdata_in,
    output var  logic [4:0] addr_out,
    output var  logic       wr_out,
    output var  logic [7:0] wdata_out
);
    initial begin
        {addr_out, wr_out, wdata_out} = '0;
    end
    // Released data is inverted so a stale byte never passes for a fresh one
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clock_in);
        {addr_out, wr_out, wdata_out} = {a, 1'b1, d};
        @(negedge clock_in);
        {wr_out, wdata_out} = {1'b0, ~d};
    endtask
    task rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clock_in);
        addr_out = a;
        @(posedge clock_in);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

/* File: verif/pcp_bank_sva.sv */
// Port assertions for the packet/clock/page bank
// Assumes a bind to pcp_bank, single clock domain
`timescale 1ns/100ps
`default_nettype none
module pcp_bank_sva (
    // Clock and reset
    input wire logic       clock_in,
    input wire logic       rst_n_in,
    // Register port
    input wire logic [4:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       page1_sel_out,
    // Packet framer status
    input wire logic       crc_done_in,
    input wire logic       crc_pass_in,
    input wire logic       rx_active_in,
    input wire logic       standby_in,
    input wire logic       rx_addr_valid_in,
    // Framer configuration
    input wire logic       manchester_en_out,
    input wire logic [6:0] pkt_length_out,
    input wire logic       var_length_out,
    input wire logic [2:0] preamble_bytes_out,
    input wire logic       scramble_en_out,
    input wire logic       crc_en_out,
    input wire logic       addr_match_out,
    input wire logic       fifo_flush_out,
    input wire logic       fifo_sel_read_out,
    input wire logic       fifo_sel_write_out,
    // Clock output pin
    input wire logic       clkout_out,
    input wire logic       clkout_oe_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    a_clk_gated: assert property (!clkout_oe_out |-> !clkout_out)
        else $error("clock output while disabled");
    a_oe_bit: assert property (reg_addr_in == 5'h1B && !page1_sel_out |->
        clkout_oe_out == reg_rdata_out[7] && reg_rdata_out[1:0] == 2'b00) else $error("oe");
    a_fmt_fields: assert property (reg_addr_in == 5'h1C && !page1_sel_out |->
        {manchester_en_out, pkt_length_out} == reg_rdata_out) else $error("format fields");
    a_ctl_fields: assert property (reg_addr_in == 5'h1E && !page1_sel_out |->
        {var_length_out, preamble_bytes_out, scramble_en_out, crc_en_out} ==
        {reg_rdata_out[7], {1'b0, reg_rdata_out[6:5]} + 3'd1, reg_rdata_out[4:3]})
        else $error("control fields");
    a_node_write: assert property (reg_wr_in && reg_addr_in == 5'h1D && !page1_sel_out ##1
        reg_addr_in == 5'h1D |-> reg_rdata_out == $past(reg_wdata_in)) else $error("node");
    a_crc_clear: assert property (reg_wr_in && reg_addr_in == 5'h1E && reg_wdata_in[0] &&
        !crc_done_in ##1 reg_addr_in == 5'h1E |-> !reg_rdata_out[0]) else $error("crc flag");
    a_flush_cause: assert property (fifo_flush_out |-> $past(crc_done_in) &&
        !$past(crc_pass_in) && $past(rx_active_in) && $past(crc_en_out) ##1 !fifo_flush_out)
        else $error("flush");
    a_fifo_route: assert property (standby_in && $past(standby_in) |->
        fifo_sel_read_out ^ fifo_sel_write_out) else $error("fifo select");
    a_page_map: assert property (reg_addr_in == 5'h1F |-> reg_rdata_out[5:2] == 4'h0 &&
        page1_sel_out == (reg_rdata_out[1:0] == 2'b01)) else $error("page");
    a_page_write: assert property (reg_wr_in && reg_addr_in == 5'h1F ##1 reg_addr_in == 5'h1F
        |-> reg_rdata_out == ($past(reg_wdata_in) & 8'hC3)) else $error("page write");
    a_match_hold: assert property (!rx_addr_valid_in |=> $stable(addr_match_out))
        else $error("address match changed without a received byte");
    c_flush: cover property (fifo_flush_out);
    c_read_fifo: cover property (standby_in && fifo_sel_read_out);
    c_page1: cover property (page1_sel_out);
    c_addr_hit: cover property (addr_match_out);
endmodule
bind pcp_bank pcp_bank_sva chk (.clock_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rdata_out, .page1_sel_out, .crc_done_in, .crc_pass_in, .rx_active_in, .standby_in,
    .rx_addr_valid_in, .manchester_en_out, .pkt_length_out, .var_length_out,
    .preamble_bytes_out, .scramble_en_out, .crc_en_out, .addr_match_out, .fifo_flush_out,
    .fifo_sel_read_out, .fifo_sel_write_out, .clkout_out, .clkout_oe_out);
`default_nettype wire

/* File: verif/packet_clock_page_config_regs_tb.sv */
// Self-checking bench for the packet/clock/page bank
// Assumes the host model drives the register port; the bench drives framer status
`timescale 1ns/100ps
`default_nettype none
module packet_clock_page_config_regs_tb;
    logic        clock_in, rst_n_in, cd, cp, ra, sb, av, wr, pg1, man, vl, scr, ce, am, fl;
    logic        fr, fw, ck, oe;
    logic [7:0]  ab, rdata, wdata, v, nd, r;
    logic [7:0]  rv [5] = '{8'hBC, 8'h00, 8'h00, 8'h40, 8'h00};
    logic [6:0]  len;
    logic [4:0]  addr;
    logic [2:0]  pre;
    logic [31:0] seed = 32'h0000_4AC7;
    int          error_cnt = 0, checks_done = 0, n, t;
    pcp_bank DUT (.clock_in, .rst_n_in, .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .page1_sel_out(pg1), .crc_done_in(cd), .crc_pass_in(cp),
        .rx_active_in(ra), .standby_in(sb), .rx_addr_valid_in(av), .rx_addr_byte_in(ab),
        .manchester_en_out(man), .pkt_length_out(len), .var_length_out(vl),
        .preamble_bytes_out(pre), .scramble_en_out(scr), .crc_en_out(ce), .addr_match_out(am),
        .fifo_flush_out(fl), .fifo_sel_read_out(fr), .fifo_sel_write_out(fw), .clkout_out(ck),
        .clkout_oe_out(oe));
    pcp_host_model host (.clock_in, .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
        .wdata_out(wdata));
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function logic hit(input logic [1:0] m, input logic [7:0] b);
        return m == 2'b00 || b == nd || (m[1] && b == 8'h00) || (&m && b == 8'hFF);
    endfunction
    task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task wrap_up();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task rdc(input logic [4:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk("register", v, e);
    endtask
    // Second rise-to-rise span only, so a divider change in flight is not measured
    task div(input logic [4:0] m);
        host.wr(5'h1B, {1'b1, m, 2'b00});
        repeat (3) begin
            for (t = 1; t < 99; t++) begin
                v[0] = ck;
                @(negedge clock_in);
                if (ck && !v[0]) break;
            end
        end
        chk("clkout period", 8'(t), {2'b00, m, 1'b0});
    endtask
    task flt(input logic [1:0] m, input logic [7:0] b);
        host.wr(5'h1E, {5'b00001, m, 1'b0});
        @(negedge clock_in);
        {av, ab} = {1'b1, b};
        @(negedge clock_in);
        {av, ab} = {1'b0, ~b};
        chk("addr match", {7'h00, am}, {7'h00, hit(m, b)});
    endtask
    task crc(input logic p, input logic [7:0] pg, input logic ef);
        host.wr(5'h1F, pg);
        @(negedge clock_in);
        {cd, cp} = {1'b1, p};
        @(negedge clock_in);
        {cd, cp} = {1'b0, ~p};
        chk("fifo flush", {7'h00, fl}, {7'h00, ef});
        rdc(5'h1E, {7'h07, p});
    endtask
    initial begin
        rst_n_in = 1'b0;
        {cd, cp, ra, sb, av, ab} = '0;
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clock_in);
        for (n = 0; n < 5; n++) rdc(5'h1B + 5'(n), rv[n]);
        rdc(5'h00, 8'h00);
        repeat (6) begin
            r = rnd();
            host.wr(5'h1C, r);
            host.wr(5'h1E, r);
            rdc(5'h1E, {r[7:1], 1'b0});
            chk("format", {man, len}, r);
            chk("length mode", {7'h00, vl}, {7'h00, r[7]});
            chk("preamble", {5'h00, pre}, {5'h00, 3'(r[6:5]) + 3'h1});
            chk("scramble crc", {6'h00, scr, ce}, {6'h00, r[4:3]});
        end
        div(5'd15);
        div(5'd1);
        div(5'(rnd()) | 5'h01);
        host.wr(5'h1B, 8'h80);
        @(posedge clock_in);
        #5 chk("clock pass", {7'h00, ck}, 8'h01);
        @(negedge clock_in);
        #5 chk("clock pass low", {7'h00, ck}, 8'h00);
        host.wr(5'h1B, 8'h3F);
        repeat (40) @(negedge clock_in) chk("clkout off", {6'h00, oe, ck}, 8'h00);
        rdc(5'h1B, 8'h3C);
        nd = rnd();
        host.wr(5'h1D, nd);
        for (n = 0; n < 16; n++) flt(2'(n), n[3] ? (n[2] ? nd ^ 8'h01 : nd) : {8{n[2]}});
        ra = 1'b1;
        crc(1'b0, 8'h00, 1'b1);
        crc(1'b0, 8'h80, 1'b0);
        crc(1'b1, 8'h00, 1'b0);
        host.wr(5'h1E, 8'h0F);
        rdc(5'h1E, 8'h0E);
        // A pass result and a host clear in one cycle: the result must win
        fork
            host.wr(5'h1E, 8'h0F);
            begin
                @(negedge clock_in);
                {cd, cp} = 2'b11;
                @(negedge clock_in);
                {cd, cp} = 2'b00;
            end
        join
        rdc(5'h1E, 8'h0F);
        @(negedge clock_in) sb = 1'b1;
        for (n = 0; n < 2; n++) begin
            host.wr(5'h1F, {1'b0, n[0], 6'h3C});
            chk("fifo select", {6'h00, fr, fw}, {6'h00, n[0], !n[0]});
        end
        sb = 1'b0;
        host.wr(5'h1F, 8'hFD);
        chk("page one", {fr, fw, 5'h00, pg1}, 8'h01);
        host.wr(5'h1C, 8'hFF);
        rdc(5'h1C, 8'h00);
        rdc(5'h1F, 8'hC1);
        host.wr(5'h1F, 8'h00);
        rdc(5'h1C, r);
        flt(2'b00, 8'h5A);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clock_in);
        chk("match after reset", {7'h00, am}, 8'h00);
        for (n = 0; n < 5; n++) rdc(5'h1B + 5'(n), rv[n]);
        wrap_up();
    end
endmodule
`default_nettype wire
